/* sprc_pkg.sv */
// Constants, register map and state types of the serial interface block
package sprc_pkg;

  // ***********************************************
  // Register byte addresses
  // ***********************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_SYS = 8'h0C;

  // ***********************************************
  // Control register fields
  // ***********************************************
  localparam int CTRL_RIE = 7;
  localparam int CTRL_DMA = 6;
  localparam int CTRL_MSTR = 5;
  localparam int CTRL_CPOL = 4;
  localparam int CTRL_CLOCK_PHASE_SELECT = 3;
  localparam int CTRL_WOM = 2;
  localparam int CTRL_EN = 1;
  localparam int CTRL_TIE = 0;
  localparam logic [7:0] CTRL_RST = 8'h28;
  localparam logic [7:0] CTRL_WMASK = 8'hBF;

  // ***********************************************
  // Status and control register fields, and the system register bit
  // ***********************************************
  localparam int STAT_RXF = 7;
  localparam int STAT_ERROR_IRQ_ENABLE = 6;
  localparam int STAT_OVR = 5;
  localparam int STAT_MODE_FAULT_FLAG = 4;
  localparam int STAT_TXE = 3;
  localparam int STAT_FDE = 2;
  localparam int SYS_BCE = 0;

  // ***********************************************
  // Serial timing: half serial clock period minus one
  // ***********************************************
  localparam logic [6:0] DIV_BD2 = 7'h01;
  localparam logic [6:0] DIV_BD8 = 7'h07;
  localparam logic [6:0] DIV_BD32 = 7'h1F;
  localparam logic [6:0] DIV_BD128 = 7'h7F;
  localparam logic [3:0] LAST_EDGE = 4'hF;

  // ***********************************************
  // Types
  // ***********************************************
  typedef enum logic [1:0] {
    SPRC_IDLE = 2'b01,
    SPRC_XFER = 2'b10
  } sprc_state_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic error_irq_enable;
    logic fde;
    logic [1:0] rate;
    logic rxf;
    logic ovr;
    logic mode_fault_flag;
    logic txe;
    logic bce;
    logic [7:0] txbuf;
    logic [7:0] rxbuf;
    logic [7:0] shreg;
    logic [7:0] rxsh;
    logic [3:0] cnt;
    sprc_state_t st;
    logic [6:0] div;
    logic sck_lvl;
    logic arm_rx;
    logic arm_ov;
    logic arm_mf;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic ss_s1;
    logic ss_s2;
    logic ss_d;
    logic mosi_s1;
    logic mosi_s2;
    logic miso_s1;
    logic miso_s2;
    logic [7:0] prdata;
  } sprc_regs_t;

  localparam sprc_regs_t SPRC_REGS_RST = '{
    ctrl: CTRL_RST, txe: 1'b1, st: SPRC_IDLE, ss_s1: 1'b1, ss_s2: 1'b1,
    ss_d: 1'b1, default: '0};

endpackage : sprc_pkg

/* sprc_core.sv */
// Serial peripheral interface: flags, interrupts, resets and pin control
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sprc_core
  import sprc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System state
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_active,
  // Serial clock pin
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  // Master-out data pin
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  // Slave-out data pin
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  // Slave select pin, active low
  input wire logic ss_n_i,
  // Pin ownership towards the shared port
  output logic own_sck,
  output logic own_mosi,
  output logic own_miso,
  output logic own_ss,
  // Interrupt requests
  output logic tx_irq,
  output logic rx_err_irq,
  output logic wake_req
);

  // ***********************************************
  // State
  // ***********************************************
  sprc_regs_t s_r;
  sprc_regs_t s_nxt;

  logic en;
  logic mstr;
  logic clock_phase_select;
  logic wom;
  logic access;
  logic hit;
  logic closed;
  logic prot;
  logic fault_cond;
  logic edge_evt;
  logic done;
  logic in_bit;
  logic [7:0] rx_byte;
  logic [6:0] reload;

  // Decoded control bits
  assign en = s_r.ctrl[CTRL_EN];
  assign mstr = s_r.ctrl[CTRL_MSTR];
  assign clock_phase_select = s_r.ctrl[CTRL_CLOCK_PHASE_SELECT];
  assign wom = s_r.ctrl[CTRL_WOM];

  // Bus qualifiers
  assign access = psel & penable;
  assign hit = (paddr == ADDR_CTRL) | (paddr == ADDR_STAT) |
               (paddr == ADDR_DATA) | (paddr == ADDR_SYS);
  // Low-power modes lock software out but leave the engine running in
  // wait; stop freezes the engine separately further down
  assign closed = wait_mode | stop_mode;
  // Break protection only holds while the break-clear enable is low;
  // reads and writes still complete on the bus; flag clearing and data register writes stop
  assign prot = break_active & ~s_r.bce;

  // Mode fault condition, only with fault detect on
  assign fault_cond = s_r.fde & en & (mstr ? ~s_r.ss_s2 :
                      ((s_r.st == SPRC_XFER) & s_r.ss_s2));

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    s_nxt = s_r;
    edge_evt = 1'b0;
    done = 1'b0;
    rx_byte = 8'h00;
    in_bit = mstr ? s_r.miso_s2 : s_r.mosi_s2;

    // Pin synchronisers
    // Pins are asynchronous to pclk: two flops each before any use, and
    // a third copy of clock and select gives the edge detectors a past
    s_nxt.sck_s1 = serial_clock_pin_i;
    s_nxt.sck_s2 = s_r.sck_s1;
    s_nxt.sck_d = s_r.sck_s2;
    s_nxt.ss_s1 = ss_n_i;
    s_nxt.ss_s2 = s_r.ss_s1;
    s_nxt.ss_d = s_r.ss_s2;
    s_nxt.mosi_s1 = mosi_i;
    s_nxt.mosi_s2 = s_r.mosi_s1;
    s_nxt.miso_s1 = miso_i;
    s_nxt.miso_s2 = s_r.miso_s1;

    // Baud divisor reload
    case (s_r.rate)
      2'b00: reload = DIV_BD2;
      2'b01: reload = DIV_BD8;
      2'b10: reload = DIV_BD32;
      default: reload = DIV_BD128;
    endcase

    // Read data captured in the setup cycle
    // Capturing in setup keeps prdata stable through the access phase
    // and lets the arm logic see exactly what software was shown
    if (psel & ~penable) begin
      case (paddr)
        ADDR_CTRL: s_nxt.prdata = s_r.ctrl & CTRL_WMASK;
        ADDR_STAT: s_nxt.prdata = {s_r.rxf, s_r.error_irq_enable, s_r.ovr, s_r.mode_fault_flag,
                                   s_r.txe, s_r.fde, s_r.rate};
        ADDR_DATA: s_nxt.prdata = s_r.rxbuf;
        ADDR_SYS: s_nxt.prdata = {7'h00, s_r.bce};
        default: s_nxt.prdata = 8'h00;
      endcase
    end

    // Register access effects, none while closed
    if (access & hit & ~closed) begin
      if (pwrite) begin
        case (paddr)
          ADDR_CTRL: begin
            s_nxt.ctrl = pwdata[7:0] & CTRL_WMASK;
            if (s_r.arm_mf & ~prot) begin
              if (~fault_cond) begin
                s_nxt.mode_fault_flag = 1'b0;
              end
              s_nxt.arm_mf = 1'b0;
            end
          end
          ADDR_STAT: begin
            s_nxt.error_irq_enable = pwdata[STAT_ERROR_IRQ_ENABLE];
            s_nxt.fde = pwdata[STAT_FDE];
            s_nxt.rate = pwdata[1:0];
          end
          ADDR_DATA: begin
            if (~prot) begin
              s_nxt.txbuf = pwdata[7:0];
              s_nxt.txe = ~en;
            end
          end
          ADDR_SYS: s_nxt.bce = pwdata[SYS_BCE];
          default: s_nxt.bce = s_r.bce;
        endcase
      end else if (~prot) begin
        // First step arms, second step clears
        // Arming from the captured word means a flag that rises after
        // the status read cannot be cleared by the following data read
        if (paddr == ADDR_STAT) begin
          s_nxt.arm_rx = s_r.prdata[STAT_RXF];
          s_nxt.arm_ov = s_r.prdata[STAT_OVR];
          s_nxt.arm_mf = s_r.prdata[STAT_MODE_FAULT_FLAG];
        end else if (paddr == ADDR_DATA) begin
          if (s_r.arm_rx) begin
            s_nxt.rxf = 1'b0;
          end
          if (s_r.arm_ov) begin
            s_nxt.ovr = 1'b0;
          end
          s_nxt.arm_rx = 1'b0;
          s_nxt.arm_ov = 1'b0;
        end
      end
    end

    // A fault during the clear sequence cancels it
    // A mode fault still present when software writes the control
    // register must leave the flag standing
    if (fault_cond) begin
      s_nxt.arm_mf = 1'b0;
    end

    // Serial engine, frozen in stop mode
    if (~stop_mode) begin
      if (~en) begin
        // Partial reset, control bits and receive and fault flags kept, transmit empty set
        // Receive and fault flags and control bits survive so software can still service
        // requests that were pending when the module was switched off
        s_nxt.txe = 1'b1;
        s_nxt.st = SPRC_IDLE;
        s_nxt.cnt = 4'h0;
        s_nxt.shreg = 8'h00;
        s_nxt.rxsh = 8'h00;
        s_nxt.div = 7'h00;
        s_nxt.sck_lvl = s_r.ctrl[CTRL_CPOL];
      end else if (mstr & s_r.fde & ~s_r.ss_s2) begin
        // Master mode fault turns the module off
        // Another master pulled select low: release the pins at once to
        // avoid driving against it
        s_nxt.mode_fault_flag = 1'b1;
        s_nxt.ctrl[CTRL_EN] = 1'b0;
        s_nxt.txe = 1'b1;
        s_nxt.st = SPRC_IDLE;
        s_nxt.cnt = 4'h0;
      end else begin
        case (s_r.st)
          SPRC_IDLE: begin
            // Idle device takes a waiting byte at once
            if (~s_r.txe) begin
              s_nxt.shreg = s_r.txbuf;
              s_nxt.txe = 1'b1;
              if (mstr) begin
                s_nxt.st = SPRC_XFER;
                s_nxt.div = reload;
                s_nxt.sck_lvl = s_r.ctrl[CTRL_CPOL];
              end
            end
            if (~mstr & ~s_r.ss_s2) begin
              if (~clock_phase_select & s_r.ss_d) begin
                // Phase zero starts on select falling
                s_nxt.st = SPRC_XFER;
                s_nxt.cnt = 4'h0;
              end else if (clock_phase_select & (s_r.sck_s2 != s_r.sck_d)) begin
                // Phase one starts on first clock edge
                s_nxt.st = SPRC_XFER;
                s_nxt.cnt = 4'h1;
              end
            end
          end
          SPRC_XFER: begin
            if (mstr) begin
              // Master generates the serial clock
              if (s_r.div == 7'h00) begin
                s_nxt.div = reload;
                s_nxt.sck_lvl = ~s_r.sck_lvl;
                edge_evt = 1'b1;
              end else begin
                s_nxt.div = s_r.div - 7'h01;
              end
            end else if (s_r.ss_s2) begin
              // Deselected slave drops the transfer
              // A slave whose select rises mid-byte stops listening at
              // once; any half-shifted data is simply dropped
              edge_evt = 1'b0;
              s_nxt.st = SPRC_IDLE;
              s_nxt.cnt = 4'h0;
              if (s_r.fde) begin
                s_nxt.mode_fault_flag = 1'b1;
              end
            end else begin
              edge_evt = s_r.sck_s2 != s_r.sck_d;
            end
            if (edge_evt) begin
              s_nxt.cnt = s_r.cnt + 4'h1;
              if (s_r.cnt[0] == clock_phase_select) begin
                // Sampling edge
                s_nxt.rxsh = {s_r.rxsh[6:0], in_bit};
              end else if (s_r.cnt != 4'h0 || ~clock_phase_select) begin
                // Shifting edge
                s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
              end
              if (s_r.cnt == LAST_EDGE) begin
                done = 1'b1;
                // Phase one ends on a sampling edge and takes the last
                // bit now; phase zero ends on a shifting edge and the
                // eight samples are already in the receive shifter
                if (s_r.cnt[0] == clock_phase_select) begin
                  rx_byte = {s_r.rxsh[6:0], in_bit};
                end else begin
                  rx_byte = s_r.rxsh;
                end
                s_nxt.st = SPRC_IDLE;
                s_nxt.cnt = 4'h0;
              end
            end
          end
          default: begin
            s_nxt.st = SPRC_IDLE;
            s_nxt.cnt = 4'h0;
          end
        endcase
      end

      // Byte completion; set wins over a same-cycle clear
      // Overrun keeps the unread byte and discards the new one; the
      // overrun flag blocks further transfers into the buffer
      if (done) begin
        if (s_nxt.ovr) begin
          s_nxt.ovr = 1'b1;
        end else if (s_nxt.rxf) begin
          s_nxt.ovr = 1'b1;
        end else begin
          s_nxt.rxbuf = rx_byte;
          s_nxt.rxf = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= SPRC_REGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  // APB answer in the access cycle
  // Zero wait states: every transfer finishes in its access cycle
  assign pready = 1'b1;
  assign pslverr = access & (~hit | closed);
  assign prdata = {24'h000000, s_r.prdata};

  // Interrupt requests: transmit on its own line, receive and errors on one shared line
  // DMA select reads zero here, so the term never masks the request
  assign tx_irq = s_r.txe & s_r.ctrl[CTRL_TIE] & en &
                  ~s_r.ctrl[CTRL_DMA];
  assign rx_err_irq = (s_r.rxf & s_r.ctrl[CTRL_RIE]) |
                      (s_r.error_irq_enable & (s_r.ovr | s_r.mode_fault_flag));
  assign wake_req = wait_mode & (tx_irq | rx_err_irq);

  // Pin ownership and drivers
  // Select pin is only taken when its level matters to the engine
  // Wired-or master-out data only pulls low, a one is left to the pull-up; slave-out drives both levels
  assign own_sck = en;
  assign own_mosi = en;
  assign own_miso = en;
  assign own_ss = en & (~mstr | s_r.fde);
  assign serial_clock_pin_o = s_r.sck_lvl;
  assign serial_clock_pin_oe = en & mstr;
  assign mosi_o = s_r.shreg[7] & ~wom;
  assign mosi_oe = en & mstr & (~wom | ~s_r.shreg[7]);
  assign miso_o = s_r.shreg[7];
  assign miso_oe = en & ~mstr & ~s_r.ss_s2;

endmodule : sprc_core

`default_nettype wire

/* sprc_core_monitor.sv */
// Port-level checker for the serial interface block
`timescale 1ns/1ps
`default_nettype none

module sprc_core_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and system state
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  input wire logic wait_mode,
  input wire logic stop_mode,
  // Pins
  input wire logic ss_n_i,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic own_sck,
  input wire logic own_mosi,
  input wire logic own_miso,
  input wire logic own_ss,
  // Requests
  input wire logic tx_irq,
  input wire logic rx_err_irq,
  input wire logic wake_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Requests and their enabling conditions, and bus errors in low power
  property p_tx_on;
    tx_irq |-> own_sck && own_mosi;
  endproperty
  a_tx_on: assert property (p_tx_on)
    else $error("tx request while module off");
  property p_tx_clr;
    $fell(tx_irq) |-> $past(psel && penable && pwrite) || !own_sck;
  endproperty
  a_tx_clr: assert property (p_tx_clr)
    else $error("tx request dropped without a write");
  property p_wake;
    wake_req |-> wait_mode && (tx_irq || rx_err_irq);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake without enabled request");
  property p_busy;
    psel && penable && (wait_mode || stop_mode) |-> pslverr;
  endproperty
  a_busy: assert property (p_busy)
    else $error("register access taken in low power");

  // Pin ownership
  property p_off;
    !own_sck |-> !serial_clock_pin_oe && !mosi_oe && !miso_oe && !own_ss;
  endproperty
  a_off: assert property (p_off)
    else $error("pin driven while module off");
  property p_own;
    own_sck |-> own_mosi && own_miso;
  endproperty
  a_own: assert property (p_own)
    else $error("data pins not owned with clock pin");
  property p_ss;
    own_ss |-> own_sck;
  endproperty
  a_ss: assert property (p_ss)
    else $error("select pin taken while off");
  property p_miso;
    miso_oe |-> !$past(ss_n_i, 2) && !serial_clock_pin_oe;
  endproperty
  a_miso: assert property (p_miso)
    else $error("slave output driven while deselected");

  // Stop freezes the engine; reset drops the requests and pin ownership
  property p_stop;
    stop_mode && $past(stop_mode) |-> $stable(serial_clock_pin_o);
  endproperty
  a_stop: assert property (p_stop)
    else $error("serial clock moved in stop");
  property p_rst;
    disable iff (1'b0) !presetn |-> !tx_irq && !rx_err_irq && !own_sck;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active in reset");

  // Main scenarios reached
  c_tx: cover property (tx_irq);
  c_rx: cover property ($rose(rx_err_irq));
  c_slave: cover property (miso_oe);
endmodule : sprc_core_monitor

bind sprc_core sprc_core_monitor u_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .pslverr, .wait_mode,
  .stop_mode, .ss_n_i, .serial_clock_pin_o, .serial_clock_pin_oe,
  .mosi_oe, .miso_oe, .own_sck, .own_mosi, .own_miso, .own_ss, .tx_irq,
  .rx_err_irq, .wake_req
);

`default_nettype wire

/* sprc_peer.sv */
// Behavioural serial slave answering the block in master mode
`timescale 1ns/1ps
`default_nettype none

module sprc_peer (
  // Clocks
  input wire logic pclk,
  input wire logic sck,
  // Link data
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // Byte exchange
  input wire logic [7:0] tx,
  output logic [7:0] rx,
  output logic [3:0] nb
);
  logic q = 1'b0;
  logic tog = 1'b0;

  // Reply loaded as select falls, first bit out at once (phase zero)
  always @(negedge sel_n) begin
    rx = tx;
    nb = 4'h0;
    q = tx[7];
  end
  // Leading edge takes a bit in, trailing edge puts the next out, MSB first
  always @(posedge sck) if (!sel_n) begin
    rx = {rx[6:0], mosi};
    nb = nb + 4'h1;
  end
  always @(negedge sck) if (!sel_n) q = rx[7];
  // Released line shows a moving pattern
  always @(posedge pclk) tog <= ~tog;
  assign miso = sel_n ? tog : q;
endmodule : sprc_peer

`default_nettype wire

/* sprc_core_tb.sv */
// Self-checking testbench for the serial interface block
`timescale 1ns/1ps
`default_nettype none

module sprc_core_tb
  import sprc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0] paddr, ptx, prx;
  logic [31:0] pwdata, prdata, rdat;
  logic wait_mode, stop_mode, break_active, ss_n, pmiso;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic own_sck, own_mosi, own_miso, own_ss, tx_irq, rx_err_irq, wake_req;
  logic [3:0] pnb;
  wire logic sck_w, mosi_w, miso_w;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  // Clock and pin resolution
  always #4 pclk = ~pclk;
  assign sck_w = sck_oe ? sck_o : 1'b0;
  assign mosi_w = mosi_oe ? mosi_o : 1'b1;
  assign miso_w = miso_oe ? miso_o : pmiso;

  sprc_core uut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .wait_mode, .stop_mode, .break_active,
    .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe), .mosi_i(mosi_w), .mosi_o, .mosi_oe,
    .miso_i(miso_w), .miso_o, .miso_oe, .ss_n_i(ss_n), .own_sck,
    .own_mosi, .own_miso, .own_ss, .tx_irq, .rx_err_irq, .wake_req
  );
  sprc_peer peer (.pclk, .sck(sck_w), .mosi(mosi_w), .sel_n(ss_n),
    .miso(pmiso), .tx(ptx), .rx(prx), .nb(pnb));

  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    comparisons++;
    if (v !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, v, e);
    end
  endtask : chk

  // One APB transfer: setup, access until ready, then one idle edge
  task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xf

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xf(a, 1'b0, 32'h0);
    chk(rdat, e);
  endtask : rd

  task automatic waitrx;
    for (int i = 0; i < 3000 && rx_err_irq !== 1'b1; i++) @(posedge pclk);
  endtask : waitrx

  task automatic tend(input string s);
    $display("test %0s done", s);
  endtask : tend

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    presetn <= 1'b0;
    {psel, penable, pwrite, wait_mode, stop_mode, break_active} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ss_n = 1'b1;
    ptx = 8'h3C;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CTRL, 32'h28);
    rd(ADDR_STAT, 32'h08);
    chk(tx_irq, 1'b0);
    rd(8'h10, 32'h0);
    chk(serr, 1'b1);
    tend("reset");
    wr(ADDR_STAT, 32'h41);
    wr(ADDR_CTRL, 32'hA3);
    chk(tx_irq, 1'b1);
    chk(sck_oe, 1'b1);
    chk(own_ss, 1'b0);
    wait_mode <= 1'b1;
    @(posedge pclk);
    chk(wake_req, 1'b1);
    xf(ADDR_CTRL, 1'b0, 32'h0);
    chk(serr, 1'b1);
    wait_mode <= 1'b0;
    tend("enable");
    ss_n <= 1'b0;
    wr(ADDR_DATA, 32'hA5);
    waitrx();
    chk(pnb, 4'h8);
    chk(prx, 8'hA5);
    rd(ADDR_STAT, 32'hC9);
    rd(ADDR_DATA, 32'h3C);
    chk(rx_err_irq, 1'b0);
    ss_n <= 1'b1;
    ptx <= 8'hC3;
    repeat (2) @(posedge pclk);
    tend("transfer");
    ss_n <= 1'b0;
    wr(ADDR_DATA, 32'h5A);
    repeat (20) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (150) @(posedge pclk);
    chk(rx_err_irq, 1'b0);
    stop_mode <= 1'b0;
    waitrx();
    chk(prx, 8'h5A);
    rd(ADDR_STAT, 32'hC9);
    break_active <= 1'b1;
    rd(ADDR_DATA, 32'hC3);
    chk(rx_err_irq, 1'b1);
    wr(ADDR_DATA, 32'h77);
    repeat (40) @(posedge pclk);
    chk(pnb, 4'h8);
    break_active <= 1'b0;
    rd(ADDR_DATA, 32'hC3);
    chk(rx_err_irq, 1'b0);
    ss_n <= 1'b1;
    tend("stop and break");
    wr(ADDR_STAT, 32'h45);
    wr(ADDR_CTRL, 32'hA3);
    chk(own_ss, 1'b1);
    ss_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(rx_err_irq, 1'b1);
    chk(own_sck, 1'b0);
    chk(tx_irq, 1'b0);
    rd(ADDR_CTRL, 32'hA1);
    rd(ADDR_STAT, 32'h5D);
    ss_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(ADDR_STAT, 32'h5D);
    wr(ADDR_CTRL, 32'hA1);
    rd(ADDR_STAT, 32'h4D);
    chk(rx_err_irq, 1'b0);
    tend("mode fault");
    wr(ADDR_STAT, 32'h41);
    wr(ADDR_CTRL, 32'h02);
    ss_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(miso_oe, 1'b1);
    chk(sck_oe, 1'b0);
    ss_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(miso_oe, 1'b0);
    chk(own_ss, 1'b1);
    tend("slave");
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_CTRL, 32'h26);
    chk(mosi_oe, 1'b1);
    chk(mosi_o, 1'b0);
    wr(ADDR_DATA, 32'h80);
    @(posedge pclk);
    chk(mosi_oe, 1'b0);
    tend("wired or");
    give_verdict();
  end
endmodule : sprc_core_tb

`default_nettype wire
